// File: logic/align_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "speed_detect_map.svh"
// align ramp rate (0.01 V/s units) and align time (ms)
module align_decode (
    input  wire logic [3:0]  ramp_code_i,
    input  wire logic [3:0]  time_code_i,
    output logic      [19:0] ramp_o,
    output logic      [15:0] time_o
);
    always_comb begin
        case (ramp_code_i)
            4'h0:    ramp_o = 20'h0000A;
            4'h1:    ramp_o = 20'h00014;
            4'h2:    ramp_o = 20'h00032;
            4'h3:    ramp_o = 20'h00064;
            4'h4:    ramp_o = 20'h000FA;
            4'h5:    ramp_o = 20'h001F4;
            4'h6:    ramp_o = 20'h002EE;
            4'h7:    ramp_o = 20'h003E8;
            4'h8:    ramp_o = 20'h009C4;
            4'h9:    ramp_o = 20'h01388;
            4'hA:    ramp_o = 20'h01D4C;
            4'hB:    ramp_o = 20'h02710;
            4'hC:    ramp_o = 20'h061A8;
            4'hD:    ramp_o = 20'h0C350;
            4'hE:    ramp_o = 20'h124F8;
            default: ramp_o = 20'h186A0;
        endcase
    end

    always_comb begin
        case (time_code_i)
            4'h0:    time_o = 16'h0005;
            4'h1:    time_o = 16'h000A;
            4'h2:    time_o = 16'h0019;
            4'h3:    time_o = 16'h0032;
            4'h4:    time_o = 16'h004B;
            4'h5:    time_o = 16'h0064;
            4'h6:    time_o = 16'h00C8;
            4'h7:    time_o = 16'h0190;
            4'h8:    time_o = 16'h0258;
            4'h9:    time_o = 16'h0320;
            4'hA:    time_o = 16'h03E8;
            4'hB:    time_o = 16'h07D0;
            4'hC:    time_o = 16'h0FA0;
            4'hD:    time_o = 16'h1770;
            4'hE:    time_o = 16'h1F40;
            default: time_o = 16'h2710;
        endcase
    end
endmodule
`default_nettype wire

// File: logic/duration_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "speed_detect_map.svh"
// brake and coast duration steps, in ms (same table for both)
module duration_decode (
    input  wire logic [3:0]  code_i,
    output logic      [15:0] ms_o
);
    always_comb begin
        case (code_i)
            4'h0:    ms_o = 16'h000A;
            4'h1:    ms_o = 16'h0032;
            4'h2:    ms_o = 16'h0064;
            4'h3:    ms_o = 16'h00C8;
            4'h4:    ms_o = 16'h012C;
            4'h5:    ms_o = 16'h0190;
            4'h6:    ms_o = 16'h01F4;
            4'h7:    ms_o = 16'h02EE;
            4'h8:    ms_o = 16'h03E8;
            4'h9:    ms_o = 16'h07D0;
            4'hA:    ms_o = 16'h0BB8;
            4'hB:    ms_o = 16'h0FA0;
            4'hC:    ms_o = 16'h1388;
            4'hD:    ms_o = 16'h1D4C;
            4'hE:    ms_o = 16'h2710;
            default: ms_o = 16'h3A98;
        endcase
    end
endmodule
`default_nettype wire

// File: logic/speed_detect_map.svh
`ifndef SPEED_DETECT_MAP_SVH
`define SPEED_DETECT_MAP_SVH
// register offsets on the management link
`define OFS_SPEED_DETECT     8'h80
`define OFS_STARTUP_ONE      8'h82
`define RESET_WORD           32'h00000000
// speed-detect word field positions
`define BIT_PARITY           31
`define BIT_INITIAL_SPEED_DETECT_ENABLE           30
`define BIT_BRAKE_EN         29
`define BIT_COAST_EN         28
`define BIT_REV_EN           27
`define BIT_FWD_EN           26
`define BIT_STATIONARY_BRAKE_ENABLE      25
`define STAT_THR_HI          24
`define STAT_THR_LO          22
`define BIT_BRAKE_STYLE      21
`define BRK_DUR_HI           16
`define BRK_DUR_LO           13
`define COAST_DUR_HI         12
`define COAST_DUR_LO         9
`define STAT_DUR_HI          8
`define STAT_DUR_LO          6
`define RESYNC_HI            5
`define RESYNC_LO            3
`define METHOD_HI            2
`define METHOD_LO            1
// reserved bits 20..17 and 0 are held at zero
`define SD_WRITE_MASK        32'hFFE1FFFE
// first start-up word field positions
`define RAMP_HI              30
`define RAMP_LO              27
`define ALIGN_HI             26
`define ALIGN_LO             23
`endif

// File: logic/speed_detect_pkg.sv
package speed_detect_pkg;
    typedef enum logic [1:0] {
        START_SINGLE_ALIGN = 2'b00,
        START_DOUBLE_ALIGN = 2'b01,
        START_INDUCTIVE    = 2'b10,
        START_SLOW_FIRST   = 2'b11
    } startup_method_t;

    typedef struct packed {
        logic            initial_speed_detect_enable;
        logic            brake_enable;
        logic            coast_enable;
        logic            reverse_resync_enable;
        logic            forward_resync_enable;
        logic            stationary_brake_enable;
        logic [15:0]     stationary_bemf_threshold_mv;
        logic            brake_style;
        logic [15:0]     brake_duration_ms;
        logic [15:0]     coast_duration_ms;
        logic [15:0]     stationary_brake_duration_ms;
        logic [15:0]     resync_min_bemf_mv;
        logic            resync_min_uses_duty;
        startup_method_t startup_method;
    } speed_cfg_t;

    typedef struct packed {
        logic [19:0] align_ramp_centivolt_per_s;
        logic [15:0] align_duration_ms;
    } startup_cfg_t;
endpackage

// File: logic/speed_detect_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "speed_detect_map.svh"
module speed_detect_regs
    import speed_detect_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              CLK_SYS_I,
    input  wire logic              RST_N_I,
    input  wire logic              WR_EN_I,
    input  wire logic              RD_EN_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [31:0]       WDATA_I,
    output logic      [31:0]       RDATA_O,
    output logic                   RVALID_O,
    output logic                   RERR_O,
    output speed_cfg_t             SPEED_CFG_O,
    output startup_cfg_t           STARTUP_CFG_O
);
    // refuse widths that cannot reach the top mapped offset
    if (ADDR_W < 8) begin : addr_w_check
        $error("address width below 8 cannot reach 82h");
    end

    logic [31:0] speed_detect_config;
    logic [31:0] startup_config_one;
    logic        hit_speed;
    logic        hit_start;

    // mV of the stationary back-EMF threshold
    function automatic logic [15:0] stat_thr_mv(input logic [2:0] c);
        case (c)
            3'h0:    stat_thr_mv = 16'h0005;
            3'h1:    stat_thr_mv = 16'h000A;
            3'h2:    stat_thr_mv = 16'h000F;
            3'h3:    stat_thr_mv = 16'h0014;
            3'h4:    stat_thr_mv = 16'h0019;
            3'h5:    stat_thr_mv = 16'h001E;
            3'h6:    stat_thr_mv = 16'h0032;
            default: stat_thr_mv = 16'h0064;
        endcase
    endfunction

    // ms of the stationary brake
    function automatic logic [15:0] stat_dur_ms(input logic [2:0] c);
        case (c)
            3'h0:    stat_dur_ms = 16'h0001;
            3'h1:    stat_dur_ms = 16'h000A;
            3'h2:    stat_dur_ms = 16'h0019;
            3'h3:    stat_dur_ms = 16'h0032;
            3'h4:    stat_dur_ms = 16'h0064;
            3'h5:    stat_dur_ms = 16'h00FA;
            3'h6:    stat_dur_ms = 16'h01F4;
            default: stat_dur_ms = 16'h03E8;
        endcase
    endfunction

    // mV of the resync floor; code 0 is duty-scaled, reported as zero here
    function automatic logic [15:0] resync_mv(input logic [2:0] c);
        case (c)
            3'h1:    resync_mv = 16'h012C;
            3'h2:    resync_mv = 16'h0190;
            3'h3:    resync_mv = 16'h01F4;
            3'h4:    resync_mv = 16'h0258;
            3'h5:    resync_mv = 16'h0320;
            3'h6:    resync_mv = 16'h03E8;
            3'h7:    resync_mv = 16'h04E2;
            default: resync_mv = 16'h0000;
        endcase
    endfunction

    // address decode; the whole address is compared with the zero-extended offset when ADDR_W is wider
    assign hit_speed = (ADDR_I == ADDR_W'(`OFS_SPEED_DETECT));
    assign hit_start = (ADDR_I == ADDR_W'(`OFS_STARTUP_ONE));

    // speed-detect word; reserved bits never store, so they read zero
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            speed_detect_config <= `RESET_WORD;
        end else if (WR_EN_I && hit_speed) begin
            speed_detect_config <= WDATA_I & `SD_WRITE_MASK;
        end
    end

    // first start-up word; unmodelled fields still store for read-back
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            startup_config_one <= `RESET_WORD;
        end else if (WR_EN_I && hit_start) begin
            startup_config_one <= WDATA_I;
        end
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O  <= `RESET_WORD;
            RVALID_O <= 1'b0;
            RERR_O   <= 1'b0;
        end else begin
            RVALID_O <= RD_EN_I;
            RERR_O   <= RD_EN_I && !hit_speed && !hit_start;
            if (RD_EN_I) begin
                if (hit_speed) begin
                    RDATA_O <= speed_detect_config;
                end else if (hit_start) begin
                    RDATA_O <= startup_config_one;
                end else begin
                    RDATA_O <= `RESET_WORD;
                end
            end
        end
    end

    logic [15:0] brk_ms;
    logic [15:0] coast_ms;
    logic [19:0] ramp_val;
    logic [15:0] align_ms;

    duration_decode u_brake_dur (
        .code_i (speed_detect_config[`BRK_DUR_HI:`BRK_DUR_LO]),
        .ms_o   (brk_ms)
    );

    duration_decode u_coast_dur (
        .code_i (speed_detect_config[`COAST_DUR_HI:`COAST_DUR_LO]),
        .ms_o   (coast_ms)
    );

    align_decode u_align (
        .ramp_code_i (startup_config_one[`RAMP_HI:`RAMP_LO]),
        .time_code_i (startup_config_one[`ALIGN_HI:`ALIGN_LO]),
        .ramp_o      (ramp_val),
        .time_o      (align_ms)
    );

    // decoded settings, registered so the algorithm sees clean values
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SPEED_CFG_O   <= '0;
            STARTUP_CFG_O <= '0;
        end else begin
            SPEED_CFG_O.initial_speed_detect_enable <= speed_detect_config[`BIT_INITIAL_SPEED_DETECT_ENABLE];
            SPEED_CFG_O.brake_enable <= speed_detect_config[`BIT_BRAKE_EN];
            SPEED_CFG_O.coast_enable <= speed_detect_config[`BIT_COAST_EN];
            SPEED_CFG_O.reverse_resync_enable <= speed_detect_config[`BIT_REV_EN];
            SPEED_CFG_O.forward_resync_enable <= speed_detect_config[`BIT_FWD_EN];
            SPEED_CFG_O.stationary_brake_enable <= speed_detect_config[`BIT_STATIONARY_BRAKE_ENABLE];
            SPEED_CFG_O.stationary_bemf_threshold_mv <=
                stat_thr_mv(speed_detect_config[`STAT_THR_HI:`STAT_THR_LO]);
            SPEED_CFG_O.brake_style <= speed_detect_config[`BIT_BRAKE_STYLE];
            SPEED_CFG_O.brake_duration_ms <= brk_ms;
            SPEED_CFG_O.coast_duration_ms <= coast_ms;
            SPEED_CFG_O.stationary_brake_duration_ms <=
                stat_dur_ms(speed_detect_config[`STAT_DUR_HI:`STAT_DUR_LO]);
            SPEED_CFG_O.resync_min_bemf_mv <=
                resync_mv(speed_detect_config[`RESYNC_HI:`RESYNC_LO]);
            SPEED_CFG_O.resync_min_uses_duty <=
                (speed_detect_config[`RESYNC_HI:`RESYNC_LO] == 3'h0);
            SPEED_CFG_O.startup_method <=
                startup_method_t'(speed_detect_config[`METHOD_HI:`METHOD_LO]);
            STARTUP_CFG_O.align_ramp_centivolt_per_s <= ramp_val;
            STARTUP_CFG_O.align_duration_ms <= align_ms;
        end
    end

    // write to speed word shows on the enable two edges later
    isd_enable_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (WR_EN_I && hit_speed) ##1 !WR_EN_I |=>
        SPEED_CFG_O.initial_speed_detect_enable == $past(WDATA_I[`BIT_INITIAL_SPEED_DETECT_ENABLE], 2))
        else $error("speed detect enable does not follow write");

    brake_enable_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        SPEED_CFG_O.brake_enable == $past(speed_detect_config[`BIT_BRAKE_EN]))
        else $error("brake enable mismatch");

    coast_enable_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        SPEED_CFG_O.coast_enable == $past(speed_detect_config[`BIT_COAST_EN]))
        else $error("coast enable mismatch");

    resync_dirs_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        {SPEED_CFG_O.reverse_resync_enable, SPEED_CFG_O.forward_resync_enable}
        == $past(speed_detect_config[`BIT_REV_EN:`BIT_FWD_EN]))
        else $error("resync enables mismatch");

    reserved_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (speed_detect_config & ~`SD_WRITE_MASK) == 32'h00000000)
        else $error("reserved bits stored");

    read_back_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (RD_EN_I && hit_start) |=> RVALID_O && !RERR_O && RDATA_O == $past(startup_config_one))
        else $error("start-up word read-back wrong");

    parity_keep_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (WR_EN_I && hit_start) |=> startup_config_one[`BIT_PARITY] == $past(WDATA_I[`BIT_PARITY]))
        else $error("parity bit not stored");

    method_code_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        SPEED_CFG_O.startup_method == $past(speed_detect_config[`METHOD_HI:`METHOD_LO]))
        else $error("start-up method mismatch");

    stat_table_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (speed_detect_config[`STAT_DUR_HI:`STAT_DUR_LO] == 3'h7) [*2] |->
        SPEED_CFG_O.stationary_brake_duration_ms == 16'h03E8)
        else $error("stationary brake 1000 ms code wrong");

    // the remaining single-bit fields follow the stored word one edge later
    fwd_resync_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        SPEED_CFG_O.forward_resync_enable == $past(speed_detect_config[`BIT_FWD_EN]))
        else $error("forward resync enable mismatch");

    stat_brake_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        SPEED_CFG_O.stationary_brake_enable == $past(speed_detect_config[`BIT_STATIONARY_BRAKE_ENABLE]))
        else $error("stationary brake enable mismatch");

    brake_style_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        SPEED_CFG_O.brake_style == $past(speed_detect_config[`BIT_BRAKE_STYLE]))
        else $error("brake style mismatch");

    // table end points and one coast mid point; code held two edges so the registered decode has caught up
    thr_top_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (speed_detect_config[`STAT_THR_HI:`STAT_THR_LO] == 3'h7) [*2] |->
        SPEED_CFG_O.stationary_bemf_threshold_mv == 16'h0064)
        else $error("stationary threshold 100 mV code wrong");

    thr_low_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (speed_detect_config[`STAT_THR_HI:`STAT_THR_LO] == 3'h0) [*2] |->
        SPEED_CFG_O.stationary_bemf_threshold_mv == 16'h0005)
        else $error("stationary threshold 5 mV code wrong");

    brake_top_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (speed_detect_config[`BRK_DUR_HI:`BRK_DUR_LO] == 4'hF) [*2] |->
        SPEED_CFG_O.brake_duration_ms == 16'h3A98)
        else $error("brake 15 s code wrong");

    coast_mid_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (speed_detect_config[`COAST_DUR_HI:`COAST_DUR_LO] == 4'h7) [*2] |->
        SPEED_CFG_O.coast_duration_ms == 16'h02EE)
        else $error("coast 750 ms code wrong");

    resync_top_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (speed_detect_config[`RESYNC_HI:`RESYNC_LO] == 3'h7) [*2] |->
        SPEED_CFG_O.resync_min_bemf_mv == 16'h04E2)
        else $error("resync 1250 mV code wrong");

    resync_duty_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (speed_detect_config[`RESYNC_HI:`RESYNC_LO] == 3'h0) [*2] |->
        SPEED_CFG_O.resync_min_uses_duty && SPEED_CFG_O.resync_min_bemf_mv == 16'h0000)
        else $error("resync duty-scaled code wrong");

    ramp_top_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (startup_config_one[`RAMP_HI:`RAMP_LO] == 4'hF) [*2] |->
        STARTUP_CFG_O.align_ramp_centivolt_per_s == 20'h186A0)
        else $error("align ramp 1000 V/s code wrong");

    align_top_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (startup_config_one[`ALIGN_HI:`ALIGN_LO] == 4'hF) [*2] |->
        STARTUP_CFG_O.align_duration_ms == 16'h2710)
        else $error("align 10 s code wrong");

    // read answers, refusals and the speed-word parity store on the management side
    speed_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (RD_EN_I && hit_speed) |=>
        RVALID_O && !RERR_O && RDATA_O == $past(speed_detect_config))
        else $error("speed word read-back wrong");

    unmapped_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (RD_EN_I && !hit_speed && !hit_start) |=>
        RVALID_O && RERR_O && RDATA_O == `RESET_WORD)
        else $error("unmapped read not refused");

    idle_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !RD_EN_I |=> !RVALID_O && $stable(RDATA_O))
        else $error("read answer without a request");

    write_ignore_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (WR_EN_I && !hit_speed && !hit_start) |=>
        speed_detect_config == $past(speed_detect_config) &&
        startup_config_one == $past(startup_config_one))
        else $error("write to unmapped place changed a word");

    speed_parity_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (WR_EN_I && hit_speed) |=> speed_detect_config[`BIT_PARITY] == $past(WDATA_I[`BIT_PARITY]))
        else $error("speed word parity bit not stored");
endmodule
`default_nettype wire

// File: test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the parsed management link: whole 32-bit words only
module host_model (
    input  wire logic        clk_i,
    output logic             wr_en_o,
    output logic             rd_en_o,
    output logic [7:0]       addr_o,
    output logic [31:0]      wdata_o
);
    // idle request lines at time zero
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 32'h00000000;
    end

    // one-cycle strobe; released lines go inverted so stale values never look valid
    task automatic write_word(input logic [7:0] a, input logic [31:0] d, input bit raw);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        addr_o  <= a;
        wdata_o <= (a == 8'h80 && !raw) ? (d & 32'hFFE1FFFE) : d;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~wdata_o;
    endtask

    // read request; the answer is collected by the bench watcher
    task automatic read_word(input logic [7:0] a);
        @(posedge clk_i);
        rd_en_o <= 1'b1;
        addr_o  <= a;
        @(posedge clk_i);
        rd_en_o <= 1'b0;
        addr_o  <= ~a;
    endtask
endmodule
`default_nettype wire

// File: test/speed_detect_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module speed_detect_regs_tb;
    import speed_detect_pkg::*;
    logic         clk;
    logic         rst_n;
    logic         wr_en;
    logic         rd_en;
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic [31:0]  rdata;
    logic         rvalid;
    logic         rerr;
    speed_cfg_t   sc;
    startup_cfg_t uc;
    logic [32:0]  notes[$];
    logic [32:0]  e;
    logic [31:0]  r;
    logic [31:0]  sw;
    logic [31:0]  uw;
    logic [3:0]   c;
    logic [7:0]   a;
    int           seed = 32'hffaf6fc5;
    int           fails = 0;
    int           comparisons = 0;
    int           cycles = 0;
    int dur_ms[16] = '{10, 50, 100, 200, 300, 400, 500, 750,
                       1000, 2000, 3000, 4000, 5000, 7500, 10000, 15000};
    int thr_mv[8] = '{5, 10, 15, 20, 25, 30, 50, 100};
    int stb_ms[8] = '{1, 10, 25, 50, 100, 250, 500, 1000};
    int res_mv[8] = '{0, 300, 400, 500, 600, 800, 1000, 1250};
    int ramp_cv[16] = '{10, 20, 50, 100, 250, 500, 750, 1000,
                        2500, 5000, 7500, 10000, 25000, 50000, 75000, 100000};
    int aln_ms[16] = '{5, 10, 25, 50, 75, 100, 200, 400,
                       600, 800, 1000, 2000, 4000, 6000, 8000, 10000};

    speed_detect_regs speed_detect_regs_i (
        .CLK_SYS_I     (clk),
        .RST_N_I       (rst_n),
        .WR_EN_I       (wr_en),
        .RD_EN_I       (rd_en),
        .ADDR_I        (addr),
        .WDATA_I       (wdata),
        .RDATA_O       (rdata),
        .RVALID_O      (rvalid),
        .RERR_O        (rerr),
        .SPEED_CFG_O   (sc),
        .STARTUP_CFG_O (uc)
    );

    host_model host_model_i (
        .clk_i   (clk),
        .wr_en_o (wr_en),
        .rd_en_o (rd_en),
        .addr_o  (addr),
        .wdata_o (wdata)
    );

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // read answers: oldest note against each valid pulse, sampled mid-cycle
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unexpected read", 33'h0, {rerr, rdata});
            end else begin
                e = notes.pop_front();
                chk("read word", e, {rerr, rdata});
            end
        end
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            close_out();
        end
    end

    // both words back to zero after reset, and the zero-code decode
    task automatic reset_view();
        notes.push_back(33'h0);
        host_model_i.read_word(8'h80);
        notes.push_back(33'h0);
        host_model_i.read_word(8'h82);
        @(negedge clk);
        chk("reset brake", 33'(10), 33'(sc.brake_duration_ms));
        chk("reset ramp", 33'(10), 33'(uc.align_ramp_centivolt_per_s));
        chk("reset align", 33'(5), 33'(uc.align_duration_ms));
    endtask

    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        reset_view();
        // every code of every multi-bit field, single-bit fields random; odd passes also set reserved bits
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            r = $random(seed);
            sw = {r[31:25], c[2:0], r[21], 4'h0, c, ~c, c[2:0], ~c[2:0], c[1:0], 1'b0};
            host_model_i.write_word(8'h80, sw | (c[0] ? 32'h001E0001 : 32'h0), c[0]);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("isd", 33'(sw[30]), 33'(sc.initial_speed_detect_enable));
            chk("brake en", 33'(sw[29]), 33'(sc.brake_enable));
            chk("coast en", 33'(sw[28]), 33'(sc.coast_enable));
            chk("reverse", 33'(sw[27]), 33'(sc.reverse_resync_enable));
            chk("forward", 33'(sw[26]), 33'(sc.forward_resync_enable));
            chk("stat brk", 33'(sw[25]), 33'(sc.stationary_brake_enable));
            chk("thr", 33'(thr_mv[c[2:0]]), 33'(sc.stationary_bemf_threshold_mv));
            chk("style", 33'(sw[21]), 33'(sc.brake_style));
            chk("brake dur", 33'(dur_ms[c]), 33'(sc.brake_duration_ms));
            chk("coast dur", 33'(dur_ms[~c]), 33'(sc.coast_duration_ms));
            chk("stat dur", 33'(stb_ms[c[2:0]]), 33'(sc.stationary_brake_duration_ms));
            chk("resync", 33'(res_mv[~c[2:0]]), 33'(sc.resync_min_bemf_mv));
            chk("duty", 33'(c[2:0] == 3'h7), 33'(sc.resync_min_uses_duty));
            chk("method", 33'(c[1:0]), 33'(sc.startup_method));
            r = $random(seed);
            uw = {r[31], c, ~c, r[22:0]};
            host_model_i.write_word(8'h82, uw, 1'b0);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("ramp", 33'(ramp_cv[c]), 33'(uc.align_ramp_centivolt_per_s));
            chk("align", 33'(aln_ms[~c]), 33'(uc.align_duration_ms));
            notes.push_back({1'b0, sw});
            host_model_i.read_word(8'h80);
            notes.push_back({1'b0, uw});
            host_model_i.read_word(8'h82);
        end
        // unmapped places answer with an error and zero data
        notes.push_back({1'b1, 32'h0});
        host_model_i.read_word(8'h84);
        notes.push_back({1'b1, 32'h0});
        host_model_i.read_word(8'h81);
        // random unmapped places: writes are dropped, reads answer with an error
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            a = r[7:0];
            if (a == 8'h80 || a == 8'h82) a = a ^ 8'h01;
            host_model_i.write_word(a, $random(seed), r[8]);
            notes.push_back({1'b1, 32'h0});
            host_model_i.read_word(a);
        end
        // the mapped words kept their last values through the stray writes
        notes.push_back({1'b0, sw});
        host_model_i.read_word(8'h80);
        notes.push_back({1'b0, uw});
        host_model_i.read_word(8'h82);
        // second reset in mid-run clears both words again
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reset_view();
        repeat (4) @(posedge clk);
        chk("notes left", 33'h0, 33'(notes.size()));
        close_out();
    end
endmodule
`default_nettype wire
